// File: hdl/space_pkg.sv
// Shared types and constants for the data-space decoder
package space_pkg;
  // Data-space map
  localparam logic [15:0] RF_TOP = 16'h001f;
  localparam logic [15:0] IO_TOP = 16'h005f;
  localparam logic [15:0] XIO_TOP = 16'h00ff;
  localparam logic [15:0] SRAM_BASE = 16'h0100;
  localparam logic [15:0] SRAM_TOP = 16'h10ff;
  localparam int SRAM_DEPTH = 4096;
  localparam logic [15:0] IO_DATA_OFS = 16'h0020;
  localparam logic [5:0] BITIO_TOP = 6'h1f;
  // Local registers, by data address
  localparam logic [15:0] FLAG_A = 16'h003b;
  localparam logic [15:0] GP0_A = 16'h003c;
  localparam logic [15:0] GP1_A = 16'h003d;
  localparam logic [15:0] NVM_CTL_A = 16'h003f;
  localparam logic [15:0] NVM_DATA_A = 16'h0040;
  localparam logic [15:0] NVM_ADDRL_A = 16'h0041;
  localparam logic [15:0] NVM_ADDRH_A = 16'h0042;
  localparam logic [15:0] GP2_A = 16'h0050;
  // Control register fields
  localparam int CTL_RE = 0;
  localparam int CTL_WS = 1;
  localparam int CTL_MWE = 2;
  localparam int CTL_RIE = 3;
  localparam int CTL_MODE = 4;
  localparam logic [7:0] GP_RST = 8'h00;
  localparam logic [1:0] MODE_RST = 2'h0;
  // Nonvolatile store
  localparam int NVM_DEPTH = 2048;
  localparam int NVM_AW = 11;
  localparam int WT_W = 18;
  // Timing
  localparam int CLK_KHZ = 40000;
  localparam logic [2:0] RD_STALL_CYC = 3'h4;
  localparam logic [2:0] WR_STALL_CYC = 3'h2;
  localparam logic [1:0] MWE_CYC = 2'h3;
  localparam int T_ATOMIC_US = 3400;
  localparam int T_SPLIT_US = 1800;
  localparam int ATOMIC_CYC = T_ATOMIC_US * (CLK_KHZ / 1000);
  localparam int SPLIT_CYC = T_SPLIT_US * (CLK_KHZ / 1000);

  typedef enum logic [2:0] {
    OP_LOAD = 3'h0, OP_STORE = 3'h1, OP_IN = 3'h2, OP_OUT = 3'h3,
    OP_BSET = 3'h4, OP_BCLR = 3'h5, OP_BTEST = 3'h6
  } op_e;
  typedef enum logic [2:0] {
    RG_RF = 3'h0, RG_IO = 3'h1, RG_XIO = 3'h2, RG_SRAM = 3'h3, RG_NONE = 3'h4
  } region_e;
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_ACCESS = 2'h1, ST_STALL = 2'h2} st_e;
  typedef enum logic [1:0] {
    MODE_ATOMIC = 2'h0, MODE_ERASE = 2'h1, MODE_WRITE = 2'h2, MODE_RSVD = 2'h3
  } mode_e;

  typedef struct packed {
    op_e op;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [2:0] bitsel;
  } cpu_req_s;
  typedef struct packed {
    logic [7:0] rdata;
    logic bit_val;
    logic err;
  } rsp_s;
  typedef struct packed {
    logic sel;
    logic we;
    logic [4:0] addr;
    logic [7:0] wdata;
  } rf_bus_s;
  typedef struct packed {
    logic sel;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] wmask;
  } periph_bus_s;
endpackage

// File: hdl/nvm_write_engine.sv
// Self-timed nonvolatile byte store and its write engine
module nvm_write_engine import space_pkg::*; #(
  parameter int WR_ATOMIC_CYC = ATOMIC_CYC,
  parameter int WR_SPLIT_CYC = SPLIT_CYC
) (
  input logic ref_clk,
  input logic por_n,
  input logic start,
  input logic [1:0] mode,
  input logic [NVM_AW-1:0] waddr,
  input logic [7:0] wdata,
  input logic [NVM_AW-1:0] raddr,
  output logic [7:0] rdata,
  output logic busy
);
  logic [7:0] mem [NVM_DEPTH];
  logic busy_r, busy_nxt, commit;
  logic [WT_W-1:0] cnt_r, cnt_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic [NVM_AW-1:0] addr_r, addr_nxt;
  logic [7:0] data_r, data_nxt, cval;

  assign rdata = mem[raddr];
  assign busy = busy_r;

  always_comb begin
    busy_nxt = busy_r;
    cnt_nxt = cnt_r;
    mode_nxt = mode_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    commit = 1'b0;
    if (!busy_r && start) begin
      busy_nxt = 1'b1;
      mode_nxt = mode;
      addr_nxt = waddr;
      data_nxt = wdata;
      cnt_nxt = (mode == MODE_ERASE || mode == MODE_WRITE) ?
                WT_W'(WR_SPLIT_CYC - 1) : WT_W'(WR_ATOMIC_CYC - 1);
    end else if (busy_r) begin
      if (cnt_r == '0) begin
        busy_nxt = 1'b0;
        commit = 1'b1;
      end else begin
        cnt_nxt = cnt_r - WT_W'(1);
      end
    end
    unique case (mode_r)
      MODE_ERASE: cval = 8'hff;
      MODE_WRITE: cval = mem[addr_r] & data_r;
      MODE_ATOMIC, MODE_RSVD: cval = data_r;
    endcase
  end

  // Only the supply reset stops it, so a CPU reset lets a write finish
  always_ff @(posedge ref_clk or negedge por_n) begin
    if (!por_n) begin
      busy_r <= 1'b0;
      cnt_r <= '0;
      mode_r <= MODE_RST;
      addr_r <= '0;
      data_r <= '0;
    end else begin
      busy_r <= busy_nxt;
      cnt_r <= cnt_nxt;
      mode_r <= mode_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (commit) mem[addr_r] <= cval;
  end

  busy_end_a: assert property (@(posedge ref_clk) disable iff (!por_n)
    busy_r && cnt_r == '0 |=> !busy_r) else $error("write strobe not cleared at time-out");
endmodule

// File: hdl/data_space_decoder.sv
// Data-space decoder with I/O, SRAM and nonvolatile store access
// Overview of operation
// - Data 0-0x1f is register file, to 0x5f standard I/O, to 0xff extended I/O.
// - SRAM spans data addresses 0x0100 up to 0x10ff.
// - An SRAM access completes in two clock cycles.
// - Nonvolatile store is a separate byte-wide space, one byte per access.
// - A nonvolatile read stalls the CPU four cycles.
// - A launched nonvolatile write stalls the CPU two cycles.
// - Writes are self-timed; a busy flag shows when the next may go.
// - A write starts only through the guarded enable-then-strobe sequence.
// - Master write enable self-clears after four cycles; later strobes do nothing.
// - The write strobe bit clears itself when the write time ends.
// - A write in progress finishes through a CPU reset.
// - Loads and stores reach every I/O location.
// - I/O 0-0x1f allow bit set, clear and bit test.
// - IN/OUT use I/O 0-0x3f, seen in data space at plus 0x20.
// - Extended I/O is reached by data loads and stores only.
// - Some status flags clear when a one is written to them.
// - Bit set and clear touch only the addressed bit.
// - Three general-purpose registers; those at or below 0x1f are bit-accessible.
module data_space_decoder import space_pkg::*; #(
  parameter int WR_ATOMIC_CYC = ATOMIC_CYC,
  parameter int WR_SPLIT_CYC = SPLIT_CYC
) (
  input logic ref_clk,
  input logic rst_n,
  input logic por_n,
  input logic req_valid,
  input cpu_req_s req,
  input logic [7:0] rf_rdata,
  input logic [7:0] periph_rdata,
  input logic [7:0] event_in,
  output logic req_ready,
  output logic done,
  output rsp_s rsp,
  output logic cpu_stall,
  output rf_bus_s rf_bus,
  output periph_bus_s periph_bus
);
  logic [7:0] sram [SRAM_DEPTH];
  st_e state_r, state_nxt;
  cpu_req_s req_r, req_nxt;
  region_e region_r, region_nxt, nreg;
  logic [15:0] daddr_r, daddr_nxt, nd;
  logic [7:0] mask_r, mask_nxt, val_r, val_nxt;
  logic err_r, err_nxt, wr_r, wr_nxt, bitop, wr, bad;
  logic done_r, done_nxt, ready_r, ready_nxt, stall_r, stall_nxt;
  logic [2:0] stall_cnt_r, stall_cnt_nxt, stall_len;
  rsp_s rsp_r, rsp_nxt;
  rf_bus_s rf_r, rf_nxt;
  periph_bus_s pb_r, pb_nxt;
  logic [7:0] gp0_r, gp0_nxt, gp1_r, gp1_nxt, gp2_r, gp2_nxt;
  logic [7:0] flags_r, flags_nxt, flag_clr;
  logic [11:0] nvm_addr_r, nvm_addr_nxt;
  logic [7:0] nvm_data_r, nvm_data_nxt;
  logic [1:0] mode_r, mode_nxt, mwe_cnt_r, mwe_cnt_nxt;
  logic rie_r, rie_nxt, mwe_r, mwe_nxt, mwe_set;
  logic start_r, start_nxt, rd_go_r, rd_go_nxt;
  logic [7:0] rd, local_rd, ctl_rd, wr1, merged;
  logic [11:0] sram_idx;
  logic sram_we, eng_busy, nvm_busy;
  logic [7:0] eng_rdata;

  function automatic logic [15:0] data_addr(cpu_req_s r);
    if (r.op inside {OP_LOAD, OP_STORE}) return r.addr;
    return 16'(r.addr[5:0]) + IO_DATA_OFS;
  endfunction

  function automatic region_e region_of(logic [15:0] a);
    if (a <= RF_TOP) return RG_RF;
    if (a <= IO_TOP) return RG_IO;
    if (a <= XIO_TOP) return RG_XIO;
    if (a <= SRAM_TOP) return RG_SRAM;
    return RG_NONE;
  endfunction

  function automatic logic is_local(logic [15:0] a);
    return a inside {FLAG_A, GP0_A, GP1_A, GP2_A, NVM_CTL_A, NVM_DATA_A,
                     NVM_ADDRL_A, NVM_ADDRH_A};
  endfunction

  function automatic logic [7:0] merge(logic [7:0] o, logic [7:0] m, logic [7:0] v);
    return (o & ~m) | (v & m);
  endfunction

  nvm_write_engine #(.WR_ATOMIC_CYC(WR_ATOMIC_CYC), .WR_SPLIT_CYC(WR_SPLIT_CYC)) u_eng (
    .ref_clk(ref_clk),
    .por_n(por_n),
    .start(start_r),
    .mode(mode_r),
    .waddr(nvm_addr_r[NVM_AW-1:0]),
    .wdata(nvm_data_r),
    .raddr(nvm_addr_r[NVM_AW-1:0]),
    .rdata(eng_rdata),
    .busy(eng_busy)
  );

  assign nvm_busy = eng_busy | start_r;
  assign sram_idx = 12'(daddr_r - SRAM_BASE);
  assign ctl_rd = {2'h0, mode_r, rie_r, mwe_r, nvm_busy, 1'b0};
  assign wr1 = val_r & mask_r;
  assign merged = merge(ctl_rd, mask_r, val_r);

  always_comb begin
    unique case (daddr_r)
      FLAG_A: local_rd = flags_r;
      GP0_A: local_rd = gp0_r;
      GP1_A: local_rd = gp1_r;
      GP2_A: local_rd = gp2_r;
      NVM_CTL_A: local_rd = ctl_rd;
      NVM_DATA_A: local_rd = nvm_data_r;
      NVM_ADDRL_A: local_rd = nvm_addr_r[7:0];
      NVM_ADDRH_A: local_rd = {4'h0, nvm_addr_r[11:8]};
      default: local_rd = 8'h00;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    req_nxt = req_r;
    region_nxt = region_r;
    daddr_nxt = daddr_r;
    mask_nxt = mask_r;
    val_nxt = val_r;
    err_nxt = err_r;
    wr_nxt = wr_r;
    done_nxt = 1'b0;
    ready_nxt = ready_r;
    stall_nxt = stall_r;
    stall_cnt_nxt = stall_cnt_r;
    rsp_nxt = rsp_r;
    rf_nxt = '0;
    pb_nxt = '0;
    gp0_nxt = gp0_r;
    gp1_nxt = gp1_r;
    gp2_nxt = gp2_r;
    flag_clr = 8'h00;
    nvm_addr_nxt = nvm_addr_r;
    nvm_data_nxt = nvm_data_r;
    mode_nxt = mode_r;
    rie_nxt = rie_r;
    mwe_nxt = mwe_r;
    mwe_cnt_nxt = mwe_cnt_r;
    mwe_set = 1'b0;
    start_nxt = 1'b0;
    rd_go_nxt = 1'b0;
    sram_we = 1'b0;
    stall_len = 3'h0;
    rd = 8'h00;
    nd = data_addr(req);
    nreg = region_of(nd);
    bitop = req.op inside {OP_BSET, OP_BCLR, OP_BTEST};
    wr = req.op inside {OP_STORE, OP_OUT, OP_BSET, OP_BCLR};
    bad = 1'b0;
    if (mwe_r) begin
      if (mwe_cnt_r == 2'h0) mwe_nxt = 1'b0;
      else mwe_cnt_nxt = mwe_cnt_r - 2'h1;
    end
    unique case (state_r)
      ST_IDLE: begin
        if (req_valid) begin
          // Short I/O forms carry six address bits, so extended I/O is unreachable
          bad = !(req.op inside {OP_LOAD, OP_STORE, OP_IN, OP_OUT, OP_BSET, OP_BCLR,
                                 OP_BTEST}) || nreg == RG_NONE;
          if (bitop && req.addr[5:0] > BITIO_TOP) bad = 1'b1;
          req_nxt = req;
          daddr_nxt = nd;
          region_nxt = nreg;
          err_nxt = bad;
          wr_nxt = wr;
          mask_nxt = bitop ? 8'(8'h01 << req.bitsel) : 8'hff;
          val_nxt = req.op == OP_BSET ? 8'hff : req.op == OP_BCLR ? 8'h00 : req.wdata;
          if (!bad && nreg == RG_RF) begin
            rf_nxt = '{sel: 1'b1, we: wr, addr: nd[4:0], wdata: req.wdata};
          end
          if (!bad && nreg inside {RG_IO, RG_XIO} && !is_local(nd)) begin
            pb_nxt = '{sel: 1'b1, we: wr, addr: nd[7:0], wdata: val_nxt,
                       wmask: mask_nxt};
          end
          ready_nxt = 1'b0;
          state_nxt = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        unique case (region_r)
          RG_RF: rd = rf_rdata;
          RG_IO, RG_XIO: rd = is_local(daddr_r) ? local_rd : periph_rdata;
          RG_SRAM: rd = sram[sram_idx];
          RG_NONE: rd = 8'h00;
        endcase
        if (err_r) rd = 8'h00;
        if (!err_r && wr_r) begin
          sram_we = region_r == RG_SRAM;
          unique case (daddr_r)
            FLAG_A: flag_clr = wr1;
            GP0_A: gp0_nxt = merge(gp0_r, mask_r, val_r);
            GP1_A: gp1_nxt = merge(gp1_r, mask_r, val_r);
            GP2_A: gp2_nxt = merge(gp2_r, mask_r, val_r);
            NVM_DATA_A: nvm_data_nxt = merge(nvm_data_r, mask_r, val_r);
            NVM_ADDRL_A: if (!nvm_busy) nvm_addr_nxt[7:0] =
                merge(nvm_addr_r[7:0], mask_r, val_r);
            NVM_ADDRH_A: if (!nvm_busy) nvm_addr_nxt[11:8] =
                4'(merge({4'h0, nvm_addr_r[11:8]}, mask_r, val_r));
            NVM_CTL_A: begin
              rie_nxt = merged[CTL_RIE];
              if (!nvm_busy) mode_nxt = merged[CTL_MODE +: 2];
              if (wr1[CTL_MWE]) begin
                mwe_set = 1'b1;
                mwe_nxt = 1'b1;
                mwe_cnt_nxt = MWE_CYC;
              end
              if (wr1[CTL_WS] && mwe_r && !nvm_busy) begin
                start_nxt = 1'b1;
                stall_len = WR_STALL_CYC;
              end else if (wr1[CTL_RE] && !nvm_busy) begin
                nvm_data_nxt = eng_rdata;
                rd_go_nxt = 1'b1;
                stall_len = RD_STALL_CYC;
              end
            end
            default: ;
          endcase
        end
        rsp_nxt = '{rdata: rd, bit_val: rd[req_r.bitsel], err: err_r};
        done_nxt = 1'b1;
        if (stall_len != 3'h0) begin
          stall_nxt = 1'b1;
          stall_cnt_nxt = stall_len - 3'h1;
          state_nxt = ST_STALL;
        end else begin
          ready_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      ST_STALL: begin
        if (stall_cnt_r == 3'h0) begin
          stall_nxt = 1'b0;
          ready_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end else begin
          stall_cnt_nxt = stall_cnt_r - 3'h1;
        end
      end
    endcase
    // A new event beats a clear in the same cycle
    flags_nxt = (flags_r & ~flag_clr) | event_in;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      req_r <= '0;
      region_r <= RG_NONE;
      daddr_r <= '0;
      mask_r <= '0;
      val_r <= '0;
      err_r <= 1'b0;
      wr_r <= 1'b0;
      done_r <= 1'b0;
      ready_r <= 1'b1;
      stall_r <= 1'b0;
      stall_cnt_r <= '0;
      rsp_r <= '0;
      rf_r <= '0;
      pb_r <= '0;
      gp0_r <= GP_RST;
      gp1_r <= GP_RST;
      gp2_r <= GP_RST;
      flags_r <= 8'h00;
      nvm_addr_r <= '0;
      nvm_data_r <= '0;
      mode_r <= MODE_RST;
      rie_r <= 1'b0;
      mwe_r <= 1'b0;
      mwe_cnt_r <= '0;
      start_r <= 1'b0;
      rd_go_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      req_r <= req_nxt;
      region_r <= region_nxt;
      daddr_r <= daddr_nxt;
      mask_r <= mask_nxt;
      val_r <= val_nxt;
      err_r <= err_nxt;
      wr_r <= wr_nxt;
      done_r <= done_nxt;
      ready_r <= ready_nxt;
      stall_r <= stall_nxt;
      stall_cnt_r <= stall_cnt_nxt;
      rsp_r <= rsp_nxt;
      rf_r <= rf_nxt;
      pb_r <= pb_nxt;
      gp0_r <= gp0_nxt;
      gp1_r <= gp1_nxt;
      gp2_r <= gp2_nxt;
      flags_r <= flags_nxt;
      nvm_addr_r <= nvm_addr_nxt;
      nvm_data_r <= nvm_data_nxt;
      mode_r <= mode_nxt;
      rie_r <= rie_nxt;
      mwe_r <= mwe_nxt;
      mwe_cnt_r <= mwe_cnt_nxt;
      start_r <= start_nxt;
      rd_go_r <= rd_go_nxt;
    end
  end

  // SRAM contents are not reset
  always_ff @(posedge ref_clk) begin
    if (sram_we) sram[sram_idx] <= val_r;
  end

  assign req_ready = ready_r;
  assign done = done_r;
  assign rsp = rsp_r;
  assign cpu_stall = stall_r;
  assign rf_bus = rf_r;
  assign periph_bus = pb_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sram_latency_a: assert property (
    state_r == ST_IDLE && req_valid && region_of(data_addr(req)) == RG_SRAM &&
    req.op inside {OP_LOAD, OP_STORE} |-> ##2 (done_r && !rsp_r.err))
    else $error("SRAM access not done in two cycles");
  rf_route_a: assert property (
    state_r == ST_IDLE && req_valid && req.op == OP_LOAD && req.addr <= RF_TOP
    |=> rf_r.sel && !rf_r.we && !pb_r.sel) else $error("register file load misrouted");
  io_offset_a: assert property (
    state_r == ST_IDLE && req_valid && req.op == OP_IN
    |=> daddr_r == 16'($past(req.addr[5:0])) + IO_DATA_OFS) else $error("bad I/O offset");
  read_stall_a: assert property (
    rd_go_r |-> stall_r[*4] ##1 !stall_r) else $error("read stall not four cycles");
  write_stall_a: assert property (
    start_r |-> stall_r[*2] ##1 (!stall_r && ready_r)) else $error("write stall not two");
  strobe_guard_a: assert property (
    start_r |-> $past(mwe_r) && $past(state_r) == ST_ACCESS)
    else $error("write launched without master enable");
  mwe_hold_a: assert property (
    $rose(mwe_r) |-> ##3 mwe_r) else $error("master enable dropped early");
  mwe_expire_a: assert property (
    mwe_r && mwe_cnt_r == 2'h0 && !mwe_set |=> !mwe_r)
    else $error("master enable outlived four cycles");
  bit_only_a: assert property (
    pb_r.sel && pb_r.we && req_r.op inside {OP_BSET, OP_BCLR} |-> $onehot(pb_r.wmask))
    else $error("bit op touched more than one bit");
  bit_range_a: assert property (
    state_r == ST_ACCESS && req_r.op inside {OP_BSET, OP_BCLR, OP_BTEST} &&
    req_r.addr[5:0] > BITIO_TOP |=> done_r && rsp_r.err)
    else $error("bit op above 0x1f accepted");
  sram_guard_a: assert property (
    sram_we |-> daddr_r >= SRAM_BASE && daddr_r <= SRAM_TOP && !rf_r.sel && !pb_r.sel)
    else $error("SRAM written outside its range");
  flag_set_a: assert property (
    event_in != 8'h00 |=> (flags_r & $past(event_in)) == $past(event_in))
    else $error("flag event lost");

  cover_sram_c: cover property (state_r == ST_ACCESS && region_r == RG_SRAM ##1 done_r);
  cover_nvm_rd_c: cover property (rd_go_r);
  cover_nvm_wr_c: cover property (start_r);
  cover_btest_c: cover property (done_r && req_r.op == OP_BTEST && rsp_r.bit_val);
endmodule

// File: verification/bus_model.sv
// Register file and peripheral register responder facing the decoder
module bus_model import space_pkg::*; (
  input wire logic ref_clk,
  input wire rf_bus_s rf_bus,
  input wire periph_bus_s periph_bus,
  output logic [7:0] rf_rdata,
  output logic [7:0] periph_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rf_mem [32];
  logic [7:0] io_mem [256];
  logic [7:0] noise_r = 8'h5a;
  initial begin
    foreach (rf_mem[i]) rf_mem[i] = 8'h00;
    foreach (io_mem[i]) io_mem[i] = 8'h00;
  end
  // Unselected read lines wander, so a late sample never looks right
  assign rf_rdata = rf_bus.sel ? rf_mem[rf_bus.addr] : noise_r;
  assign periph_rdata = periph_bus.sel ? io_mem[periph_bus.addr] : ~noise_r;
  always @(posedge ref_clk) begin
    noise_r <= {noise_r[6:0], noise_r[7]} ^ 8'h01;
    if (rf_bus.sel && rf_bus.we) begin
      rf_mem[rf_bus.addr] <= rf_bus.wdata;
    end
    // Masked write, so a bit operation must not disturb its neighbours
    if (periph_bus.sel && periph_bus.we) begin
      io_mem[periph_bus.addr] <= (io_mem[periph_bus.addr] & ~periph_bus.wmask) |
                                 (periph_bus.wdata & periph_bus.wmask);
    end
  end
endmodule

// File: verification/data_space_decoder_tb.sv
// Self-checking testbench for the data-space decoder
module data_space_decoder_tb import space_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] CTL_IO = NVM_CTL_A - IO_DATA_OFS;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic por_n = 1'b0;
  logic req_valid = 1'b0;
  logic [7:0] event_in = 8'h00;
  logic [7:0] rf_rdata;
  logic [7:0] periph_rdata;
  logic req_ready;
  logic done;
  logic cpu_stall;
  cpu_req_s req = '0;
  rsp_s rsp;
  rsp_s got;
  rf_bus_s rf_bus;
  rf_bus_s rf_seen;
  periph_bus_s periph_bus;
  periph_bus_s io_seen;
  int errors = 0;
  int compares = 0;
  int lat;
  int stalls;

  always #12.5 ref_clk = ~ref_clk;

  data_space_decoder #(.WR_ATOMIC_CYC(20), .WR_SPLIT_CYC(10)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .por_n(por_n), .req_valid(req_valid), .req(req),
    .rf_rdata(rf_rdata), .periph_rdata(periph_rdata), .event_in(event_in),
    .req_ready(req_ready), .done(done), .rsp(rsp), .cpu_stall(cpu_stall),
    .rf_bus(rf_bus), .periph_bus(periph_bus));

  bus_model i_model (.ref_clk(ref_clk), .rf_bus(rf_bus), .periph_bus(periph_bus),
    .rf_rdata(rf_rdata), .periph_rdata(periph_rdata));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // Called at a falling edge; request held until the edge that takes it
  task automatic access(input op_e op, input logic [15:0] a, input logic [7:0] wd = 8'h00,
                        input logic [2:0] bs = 3'h0);
    int n;
    n = 0;
    req_valid = 1'b1;
    req = '{op: op, addr: a, wdata: wd, bitsel: bs};
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    req_valid = 1'b0;
    rf_seen = rf_bus;
    io_seen = periph_bus;
    lat = 1;
    while (done !== 1'b1 && lat < 10) begin
      @(negedge ref_clk);
      lat++;
    end
    got = rsp;
    if (n == 50 || done !== 1'b1) errors++;
    stalls = 0;
    while (cpu_stall === 1'b1 && stalls < 10) begin
      @(negedge ref_clk);
      stalls++;
    end
    if (stalls == 10) errors++;
  endtask

  task automatic t_map();
    logic [15:0] a [8] = '{16'h0000, 16'h001f, 16'h0020, 16'h005f, 16'h0060, 16'h00ff,
                           SRAM_BASE, SRAM_TOP};
    foreach (a[i]) begin
      access(OP_STORE, a[i], 8'h11 + 8'(i));
      access(OP_LOAD, a[i]);
      check("map data", got.rdata, 8'h11 + 8'(i));
      check("latency", 16'(lat), 16'h0002);
      check("rf strobe", rf_seen.sel, a[i] <= RF_TOP);
      check("io strobe", io_seen.sel, a[i] > RF_TOP && a[i] <= XIO_TOP);
      if (a[i] <= XIO_TOP) begin
        check("bus addr", a[i] <= RF_TOP ? rf_seen.addr : io_seen.addr, a[i][7:0]);
      end
    end
    access(OP_LOAD, SRAM_TOP + 16'h0001);
    check("unmapped err", got.err, 1'b1);
    access(op_e'(3'h7), 16'h0000);
    check("illegal err", got.err, 1'b1);
    $display("test map finished");
  endtask

  task automatic t_io();
    access(OP_OUT, 16'h0000, 8'h77);
    check("out addr", io_seen.addr, 8'h20);
    access(OP_LOAD, 16'h0020);
    check("out alias", got.rdata, 8'h77);
    access(OP_OUT, 16'h0005, 8'h81);
    access(OP_BSET, 16'h0005, 8'h00, 3'h3);
    check("set mask", io_seen.wmask, 8'h08);
    access(OP_BCLR, 16'h0005, 8'h00, 3'h0);
    access(OP_IN, 16'h0005);
    check("bit ops", got.rdata, 8'h88);
    access(OP_BTEST, 16'h0005, 8'h00, 3'h3);
    check("bit test 1", got.bit_val, 1'b1);
    access(OP_BTEST, 16'h0005, 8'h00, 3'h0);
    check("bit test 0", got.bit_val, 1'b0);
    access(OP_BSET, 16'h0020, 8'h00, 3'h1);
    check("bit range err", got.err, 1'b1);
    check("bit range strobe", io_seen.sel, 1'b0);
    $display("test io finished");
  endtask

  task automatic t_regs();
    access(OP_LOAD, GP0_A);
    check("gp reset", got.rdata, GP_RST);
    access(OP_STORE, GP0_A, 8'hc3);
    access(OP_STORE, GP2_A, 8'h5a);
    access(OP_BSET, GP1_A - IO_DATA_OFS, 8'h00, 3'h7);
    access(OP_LOAD, GP0_A);
    check("gp0", got.rdata, 8'hc3);
    access(OP_LOAD, GP2_A);
    check("gp2", got.rdata, 8'h5a);
    access(OP_BTEST, GP1_A - IO_DATA_OFS, 8'h00, 3'h7);
    check("gp1 bit", got.bit_val, 1'b1);
    event_in = 8'h24;
    @(negedge ref_clk);
    event_in = 8'h00;
    access(OP_BSET, FLAG_A - IO_DATA_OFS, 8'h00, 3'h2);
    access(OP_LOAD, FLAG_A);
    check("flag one bit", got.rdata, 8'h20);
    access(OP_STORE, FLAG_A, 8'h20);
    access(OP_LOAD, FLAG_A);
    check("flag w1c", got.rdata, 8'h00);
    $display("test regs finished");
  endtask

  task automatic nvm_addr(input logic [11:0] a);
    access(OP_STORE, NVM_ADDRL_A, a[7:0]);
    access(OP_STORE, NVM_ADDRH_A, {4'h0, a[11:8]});
  endtask

  task automatic nvm_start(input logic [11:0] a, input logic [7:0] d);
    nvm_addr(a);
    access(OP_STORE, NVM_DATA_A, d);
    // Single-bit sets keep reserved control bits at zero
    access(OP_BSET, CTL_IO, 8'h00, 3'(CTL_MWE));
    access(OP_BSET, CTL_IO, 8'h00, 3'(CTL_WS));
    check("write stall", 16'(stalls), 16'h0002);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    access(OP_LOAD, NVM_CTL_A);
    check("busy shown", got.rdata[CTL_WS], 1'b1);
    while (got.rdata[CTL_WS] === 1'b1 && n < 40) begin
      access(OP_LOAD, NVM_CTL_A);
      n++;
    end
    check("busy clears", got.rdata[CTL_WS], 1'b0);
  endtask

  task automatic nvm_get(input logic [11:0] a, output logic [7:0] d);
    nvm_addr(a);
    access(OP_BSET, CTL_IO, 8'h00, 3'(CTL_RE));
    check("read stall", 16'(stalls), 16'h0004);
    access(OP_LOAD, NVM_DATA_A);
    d = got.rdata;
  endtask

  task automatic t_nvm();
    logic [7:0] d;
    nvm_start(12'h7ff, 8'h96);
    wait_idle();
    nvm_start(12'h000, 8'h69);
    wait_idle();
    nvm_get(12'h7ff, d);
    check("store high", d, 8'h96);
    nvm_get(12'h000, d);
    check("store low", d, 8'h69);
    // Split modes: erase, then write-only, then back to atomic
    access(OP_STORE, NVM_CTL_A, 8'h18);
    access(OP_LOAD, NVM_CTL_A);
    check("mode bits", got.rdata, 8'h18);
    nvm_start(12'h7ff, 8'h00);
    wait_idle();
    nvm_get(12'h7ff, d);
    check("erased", d, 8'hff);
    access(OP_STORE, NVM_CTL_A, 8'h20);
    nvm_start(12'h7ff, 8'h5a);
    wait_idle();
    nvm_get(12'h7ff, d);
    check("write only", d, 8'h5a);
    access(OP_STORE, NVM_CTL_A, 8'h00);
    $display("test nvm finished");
  endtask

  task automatic t_guard();
    logic [7:0] d;
    nvm_addr(12'h000);
    access(OP_STORE, NVM_DATA_A, 8'h00);
    access(OP_BSET, CTL_IO, 8'h00, 3'(CTL_WS));
    check("bare strobe", 16'(stalls), 16'h0000);
    access(OP_BSET, CTL_IO, 8'h00, 3'(CTL_MWE));
    // Let the enable window lapse before the strobe
    repeat (6) @(negedge ref_clk);
    access(OP_LOAD, NVM_CTL_A);
    check("enable lapsed", got.rdata[CTL_MWE], 1'b0);
    access(OP_BSET, CTL_IO, 8'h00, 3'(CTL_WS));
    check("late strobe", 16'(stalls), 16'h0000);
    nvm_get(12'h000, d);
    check("no write", d, 8'h69);
    $display("test guard finished");
  endtask

  task automatic t_reset_mid();
    logic [7:0] d;
    nvm_start(12'h123, 8'h3e);
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    wait_idle();
    nvm_get(12'h123, d);
    check("write survives", d, 8'h3e);
    $display("test reset finished");
  endtask

  task automatic give_verdict();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Whole run is a few hundred cycles; this leaves wide margin
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    give_verdict();
  end

  initial begin
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    por_n = 1'b1;
    t_map();
    t_io();
    t_regs();
    t_nvm();
    t_guard();
    t_reset_mid();
    give_verdict();
  end
endmodule
